// ===== srnv_pkg.sv
// constants shared by the reset and nmi vector block
package srnv_pkg;
  localparam logic [15:0] USER_NMI_VECTOR_OFS   = 16'h015A;
  localparam logic [15:0] SYSTEM_NMI_VECTOR_OFS = 16'h015C;
  localparam logic [15:0] RESET_CAUSE_VECTOR_OFS = 16'h015E;
  localparam logic [15:0] MAILBOX_IN_DATA_OFS   = 16'h0190;
  localparam logic [15:0] MAILBOX_OUT_DATA_OFS  = 16'h0192;
  localparam int RST_BITS = 32;
  localparam int NMI_BITS = 16;
  // event bit n carries vector code 2*n
  localparam logic [31:0] RST_VALID_MASK = 32'h0005_FCBE;
  localparam logic [31:0] RST_BOR_MASK   = 32'h0000_00BE;
  localparam logic [31:0] RST_POR_MASK   = 32'h0000_0400;
  localparam logic [31:0] RST_PUC_MASK   = 32'h0005_F800;
  localparam logic [15:0] SNMI_EXT_MASK  = 16'h1206;
  localparam int SNMI_MBOX_IN_BIT  = 10;
  localparam int SNMI_MBOX_OUT_BIT = 11;
  localparam logic [15:0] UNMI_VALID_MASK = 16'h0006;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
endpackage

// ===== srnv_prio.sv
// lowest-index pending source and its vector code
`timescale 1ns/1ps
`default_nettype none
module srnv_prio #(
  parameter int N = 32
) (
  input  wire logic [N-1:0] pend_i,
  output logic      [15:0]  code_o,
  output logic      [N-1:0] first_o
);
  // elaboration-time refusal of widths the priority logic cannot serve
  if (N < 2 || N > 128) begin : g_bad_n
    $error("srnv_prio: N out of range");
  end

  function automatic logic [N-1:0] lowest_bit(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = v & (~v + {{(N-1){1'b0}}, 1'b1});
    return r;
  endfunction

  function automatic logic [15:0] code_of(input logic [N-1:0] onehot);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 1; i < N; i++) begin
      if (onehot[i]) begin
        c = 16'(2 * i);
      end
    end
    return c;
  endfunction

  // bit 0 never pends, so the idle code is zero
  assign first_o = lowest_bit({pend_i[N-1:1], 1'b0});
  assign code_o  = code_of(first_o);
endmodule // srnv_prio
`default_nettype wire

// ===== srnv_top.sv
// reset cause and nmi vector registers with debug mailbox
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset cause vector at 015Eh reads 00h idle, brownout class codes 02h..0Ah and 0Eh.
// - software power-on reset reads 14h, watchdog time-out reads 16h and forces a power-up clear.
// - watchdog, memory controller and power manager key violations read 18h, 1Ah, 20h and force a power-up clear.
// - memory uncorrectable error 1Ch, peripheral fetch 1Eh, loop unlock 24h; other codes reserved.
// - system nmi vector at 015Ch reads 00h idle, 02h for supervisor low-power entry, 04h for memory error.
// - system nmi codes 12h unpopulated access, 14h mailbox input, 16h mailbox output.
// - system nmi code 18h corrected memory error; other codes reserved.
// - user nmi vector at 015Ah reads 00h idle, 02h for nmi pin or supervisor, 04h oscillator fault.
// - the block turns reset causes into brownout, power-on and power-up clear requests, and nmi and mailbox events into nmi requests.
// - a mailbox passes words between the debug link and the application.
module srnv_top (
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic        RD_I,
  input  wire logic        WR_I,
  input  wire logic [15:0] WDATA_I,
  output logic      [15:0] RDATA_O,
  input  wire logic [31:0] RST_EVT_I,
  input  wire logic [15:0] SNMI_EVT_I,
  input  wire logic [15:0] UNMI_EVT_I,
  input  wire logic        DBG_WR_I,
  input  wire logic [15:0] DBG_WDATA_I,
  input  wire logic        DBG_RD_I,
  output logic      [15:0] DBG_RDATA_O,
  output logic             BOR_REQ_O,
  output logic             POR_REQ_O,
  output logic             PUC_REQ_O,
  output logic             SYS_NMI_O,
  output logic             USER_NMI_O
);
  localparam int RB = srnv_pkg::RST_BITS;
  localparam int NB = srnv_pkg::NMI_BITS;

  logic [RB-1:0] rst_pend_r;
  logic [RB-1:0] rst_pend_nxt;
  logic [NB-1:0] snmi_pend_r;
  logic [NB-1:0] snmi_pend_nxt;
  logic [NB-1:0] unmi_pend_r;
  logic [NB-1:0] unmi_pend_nxt;
  logic [15:0]   mbox_in_r;
  logic [15:0]   mbox_out_r;
  logic [15:0]   rdata_nxt;

  wire logic [15:0]   rst_code;
  wire logic [15:0]   snmi_code;
  wire logic [15:0]   unmi_code;
  wire logic [RB-1:0] rst_first;
  wire logic [NB-1:0] snmi_first;
  wire logic [NB-1:0] unmi_first;

  wire logic hit_rst  = RD_I && (ADDR_I == srnv_pkg::RESET_CAUSE_VECTOR_OFS);
  wire logic hit_snmi = RD_I && (ADDR_I == srnv_pkg::SYSTEM_NMI_VECTOR_OFS);
  wire logic hit_unmi = RD_I && (ADDR_I == srnv_pkg::USER_NMI_VECTOR_OFS);
  wire logic hit_min  = RD_I && (ADDR_I == srnv_pkg::MAILBOX_IN_DATA_OFS);
  wire logic hit_mout = RD_I && (ADDR_I == srnv_pkg::MAILBOX_OUT_DATA_OFS);
  // only the mailbox output word takes writes
  wire logic wr_mout  = WR_I && (ADDR_I == srnv_pkg::MAILBOX_OUT_DATA_OFS);

  wire logic [RB-1:0] rst_set = RST_EVT_I & srnv_pkg::RST_VALID_MASK;
  wire logic [NB-1:0] mbox_set = (NB'(DBG_WR_I) << srnv_pkg::SNMI_MBOX_IN_BIT)
                               | (NB'(DBG_RD_I) << srnv_pkg::SNMI_MBOX_OUT_BIT);
  wire logic [NB-1:0] snmi_set = (SNMI_EVT_I & srnv_pkg::SNMI_EXT_MASK) | mbox_set;
  wire logic [NB-1:0] unmi_set = UNMI_EVT_I & srnv_pkg::UNMI_VALID_MASK;

  srnv_prio #(.N(RB)) u_rst_prio (
    .pend_i  (rst_pend_r),
    .code_o  (rst_code),
    .first_o (rst_first)
  );
  srnv_prio #(.N(NB)) u_snmi_prio (
    .pend_i  (snmi_pend_r),
    .code_o  (snmi_code),
    .first_o (snmi_first)
  );
  srnv_prio #(.N(NB)) u_unmi_prio (
    .pend_i  (unmi_pend_r),
    .code_o  (unmi_code),
    .first_o (unmi_first)
  );

  assign rst_pend_nxt  = (rst_pend_r & ~(hit_rst ? rst_first : '0)) | rst_set;
  assign snmi_pend_nxt = (snmi_pend_r & ~(hit_snmi ? snmi_first : '0)) | snmi_set;
  assign unmi_pend_nxt = (unmi_pend_r & ~(hit_unmi ? unmi_first : '0)) | unmi_set;

  // vectors read only, unmapped reads zero
  assign rdata_nxt = hit_rst  ? rst_code :
                     hit_snmi ? snmi_code :
                     hit_unmi ? unmi_code :
                     hit_min  ? mbox_in_r :
                     hit_mout ? mbox_out_r : 16'h0000;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_pend_r  <= '0;
      snmi_pend_r <= '0;
      unmi_pend_r <= '0;
      RDATA_O     <= srnv_pkg::DATA_RESET;
    end else begin
      rst_pend_r  <= rst_pend_nxt;
      snmi_pend_r <= snmi_pend_nxt;
      unmi_pend_r <= unmi_pend_nxt;
      RDATA_O     <= rdata_nxt;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mbox_in_r   <= srnv_pkg::DATA_RESET;
      mbox_out_r  <= srnv_pkg::DATA_RESET;
      DBG_RDATA_O <= srnv_pkg::DATA_RESET;
    end else begin
      if (DBG_WR_I) begin
        mbox_in_r <= DBG_WDATA_I;
      end
      if (wr_mout) begin
        mbox_out_r <= WDATA_I;
      end
      if (DBG_RD_I) begin
        DBG_RDATA_O <= mbox_out_r;
      end
    end
  end

  // memory and loop faults give clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      BOR_REQ_O  <= 1'b0;
      POR_REQ_O  <= 1'b0;
      PUC_REQ_O  <= 1'b0;
      SYS_NMI_O  <= 1'b0;
      USER_NMI_O <= 1'b0;
    end else begin
      BOR_REQ_O  <= |(rst_set & srnv_pkg::RST_BOR_MASK);
      POR_REQ_O  <= |(rst_set & srnv_pkg::RST_POR_MASK);
      PUC_REQ_O  <= |(rst_set & srnv_pkg::RST_PUC_MASK);
      SYS_NMI_O  <= |snmi_pend_nxt;
      USER_NMI_O <= |unmi_pend_nxt;
    end
  end
endmodule // srnv_top
`default_nettype wire

// ===== srnv_top_properties.sv
// port assertions for the vector block
`timescale 1ns/1ps
`default_nettype none
module srnv_top_chk (
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        RD_I,
  input wire logic        DBG_WR_I,
  input wire logic        BOR_REQ_O,
  input wire logic        POR_REQ_O,
  input wire logic        PUC_REQ_O,
  input wire logic        SYS_NMI_O,
  input wire logic        USER_NMI_O,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [15:0] UNMI_EVT_I,
  input wire logic [31:0] RST_EVT_I
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence user_rd; UNMI_EVT_I[1] ##1 !RD_I ##1 RD_I && ADDR_I == 16'h15A; endsequence
  rd_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0) else $error("rdata");
  bor_req_a: assert property (BOR_REQ_O == $past(|(RST_EVT_I & 32'hBE))) else $error("bor");
  por_req_a: assert property (RST_EVT_I[10] |=> POR_REQ_O) else $error("por");
  puc_req_a: assert property ($rose(PUC_REQ_O) |-> $past(|(RST_EVT_I & 32'h5F800))) else $error("puc");
  rst_code_a: assert property (RD_I && ADDR_I == 16'h15E |=> !RDATA_O[0] && RDATA_O <= 16'h24) else $error("rcode");
  mbox_nmi_a: assert property (DBG_WR_I |=> SYS_NMI_O) else $error("mbox");
  user_lvl_a: assert property (UNMI_EVT_I[2] |=> USER_NMI_O) else $error("unmi");
  user_first_a: assert property (user_rd |=> RDATA_O == 16'h2) else $error("ucode");
endmodule // srnv_top_chk
bind srnv_top srnv_top_chk srnv_top_chk_i (.*);
`default_nettype wire

// ===== srnv_dbg_tool.sv
// debug tool model on the mailbox side
`timescale 1ns/1ps
`default_nettype none
module srnv_dbg_tool (
  input wire logic clk_i,
  output var logic wr_o, rd_o, output var logic [15:0] data_o);
  initial {wr_o, rd_o, data_o} = 18'h0;
  task xfer(input logic w, input logic [15:0] d);
    @(posedge clk_i);
    {data_o, wr_o, rd_o} <= {d, w, !w};
    @(posedge clk_i);
    {data_o, wr_o, rd_o} <= {~d, 2'b00};
  endtask
endmodule // srnv_dbg_tool
`default_nettype wire

// ===== srnv_top_test.sv
// self-checking test of the vector block
`timescale 1ns/1ps
`default_nettype none
module srnv_top_test;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, dw, dr;
  logic [15:0] adr = 16'h0, wd = 16'h0, rdat, dwd, drd;
  logic [63:0] evt = 64'h0;
  int err_total = 0, n_compared = 0;
  srnv_top srnv_top_i (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(adr), .RD_I(rd), .WR_I(wr), .WDATA_I(wd),
    .RDATA_O(rdat), .RST_EVT_I(evt[63:32]), .SNMI_EVT_I(evt[31:16]), .UNMI_EVT_I(evt[15:0]), .DBG_WR_I(dw),
    .DBG_WDATA_I(dwd), .DBG_RD_I(dr), .DBG_RDATA_O(drd), .BOR_REQ_O(), .POR_REQ_O(), .PUC_REQ_O(),
    .SYS_NMI_O(), .USER_NMI_O());
  srnv_dbg_tool srnv_dbg_tool_i (.clk_i(clk), .wr_o(dw), .rd_o(dr), .data_o(dwd));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [15:0] s, e, input string nm);
    n_compared++;
    if (s !== e) $display("Error %s expected %h seen %h", nm, e, s);
    if (s !== e) err_total++;
  endtask
  task acc(input logic w, input logic [15:0] a, d);
    @(posedge clk);
    {adr, wd, rd, wr} <= {a, d, !w, w};
    @(posedge clk);
    {rd, wr} <= 2'b00;
    #1 if (!w) chk(rdat, d, "RDATA_O");
  endtask
  task ev(input logic [63:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 64'h0;
  endtask
  // one source at a time, in rising code order
  task scan(input logic [15:0] a, input logic [31:0] ok, input int sh, nb);
    for (int n = 0; n < nb; n++) begin
      ev(64'h1 << (n + sh));
      acc(1'b0, a, ok[n] ? 16'(2 * n) : 16'h0);
    end
  endtask
  task complete_run;
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    scan(16'h015E, 32'h0005_FCBE, 32, 32);
    scan(16'h015C, 32'h0000_1206, 16, 16);
    scan(16'h015A, 32'h0000_0006, 0, 16);
    ev(64'h0004_0804_0000_0000);
    acc(1'b1, 16'h015E, 16'hFFFF);
    acc(1'b0, 16'h015E, 16'h0004);
    acc(1'b0, 16'h015E, 16'h0016);
    srnv_dbg_tool_i.xfer(1'b1, 16'hA5C3);
    acc(1'b0, 16'h0190, 16'hA5C3);
    acc(1'b0, 16'h015C, 16'h0014);
    acc(1'b1, 16'h0192, 16'h3C5A);
    srnv_dbg_tool_i.xfer(1'b0, 16'h0000);
    #1 chk(drd, 16'h3C5A, "DBG_RDATA_O");
    acc(1'b0, 16'h015C, 16'h0016);
    complete_run;
  end
endmodule // srnv_top_test
`default_nettype wire
